// >>> hw/rcf_regs.svh
// Register map, field positions and reset values of the reset-cause flags
//
// Contract
// - Stack overflow reset sets bit 7 of the low flag register.
// - Stack underflow reset sets bit 6 of the low flag register.
// - Watchdog clear in closed window reset clears bit 5.
// - Watchdog time-out reset clears bit 4; stays one otherwise.
// - External pin reset clears bit 3; reads one until then.
// - Reset instruction clears bit 2.
// - Power-on reset clears bit 1 of the low flag register.
// - Brown-out reset clears bit 0 of the low flag register.
// - Memory execution violation reset clears bit 1 of the high register.
// - Firmware may write every flag to re-arm or clear it.
// - High register bits 7 to 2 and bit 0 always read zero.
// - Only the flag of the actual cause changes; others keep value.
// - Firmware writing a flag active only stores it, no reset.
// - Brown-out ready reads one when armed, zero when off or warming; code follows i_bor_armed, not software_brownout_enable.
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

`define RCF_OFS_FLAGS_LO 8'h00
`define RCF_OFS_FLAGS_HI 8'h04
`define RCF_OFS_BOR_CTL 8'h08
`define RCF_OFS_IRQ_STS 8'h0C
`define RCF_OFS_IRQ_MSK 8'h10

`define RCF_BIT_STK_OVF 7
`define RCF_BIT_STK_UNF 6
`define RCF_BIT_WDT_WIN 5
`define RCF_BIT_WDT_TO 4
`define RCF_BIT_PIN 3
`define RCF_BIT_SW 2
`define RCF_BIT_POR 1
`define RCF_BIT_BOR 0
`define RCF_BIT_MEMORY_VIOLATION_FLAG 1
`define RCF_BIT_SOFTWARE_BROWNOUT_ENABLE 7
`define RCF_BIT_BOR_RDY 0

`define RCF_FLAGS_LO_RST 8'h3C
`define RCF_MEMORY_VIOLATION_FLAG_RST 1'b1
`define RCF_SOFTWARE_BROWNOUT_ENABLE_RST 1'b1
`define RCF_RESP_OKAY 2'h0
`define RCF_RESP_SLVERR 2'h2

`endif

// >>> hw/rcf_pkg.sv
// Types of the reset-cause flag block
package rcf_pkg;

   typedef enum logic [5:0] {
      RCF_SEL_NONE = 6'h01,
      RCF_SEL_LO = 6'h02,
      RCF_SEL_HI = 6'h04,
      RCF_SEL_BOR = 6'h08,
      RCF_SEL_STS = 6'h10,
      RCF_SEL_MSK = 6'h20
   } rcf_sel_t;

   typedef struct packed {
      logic [7:0] evt_s1;
      logic [7:0] evt_s2;
      logic [7:0] evt_s3;
      logic strap_done;
      logic [7:0] flags_lo;
      logic memory_violation_flag;
      logic software_brownout_enable;
      logic [7:0] irq_sts;
      logic [7:0] irq_msk;
      logic irq;
      logic awready;
      logic [7:0] aw_addr;
      logic wready;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rcf_state_t;

endpackage

// >>> hw/rcf_top.sv
// Reset-cause flag registers with AXI4-Lite slave and interrupt
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "rcf_regs.svh"

module rcf_top #(
   parameter int ADDR_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_bor_cause,
   input wire logic i_evt_stk_ovf,
   input wire logic i_evt_stk_unf,
   input wire logic i_evt_wdt_win,
   input wire logic i_evt_wdt_to,
   input wire logic i_evt_pin,
   input wire logic i_evt_sw,
   input wire logic i_evt_memory_violation_flag,
   input wire logic i_bor_armed,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_software_brownout_enable,
   output logic o_irq
);
   import rcf_pkg::*;

   localparam rcf_state_t ST_RST = '{
      flags_lo: `RCF_FLAGS_LO_RST,
      memory_violation_flag: `RCF_MEMORY_VIOLATION_FLAG_RST,
      software_brownout_enable: `RCF_SOFTWARE_BROWNOUT_ENABLE_RST,
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      default: '0
   };

   // Refuse address widths the decoder cannot serve
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must be 5 to 32");
   end

   rcf_state_t s_r;
   rcf_state_t s_nxt;
   logic [1:0] rst_q_r;
   logic rst_n_s;
   logic [7:0] rise;
   rcf_sel_t wsel;
   rcf_sel_t rsel;

   // Decode the low byte of an address to a register select
   function automatic rcf_sel_t dec(input logic [ADDR_W-1:0] a);
      logic [7:0] lo;
      rcf_sel_t r;
      lo = 8'(a);
      r = RCF_SEL_NONE;
      if (a[ADDR_W-1:0] == ADDR_W'(lo)) begin
         case (lo)
            `RCF_OFS_FLAGS_LO: r = RCF_SEL_LO;
            `RCF_OFS_FLAGS_HI: r = RCF_SEL_HI;
            `RCF_OFS_BOR_CTL: r = RCF_SEL_BOR;
            `RCF_OFS_IRQ_STS: r = RCF_SEL_STS;
            `RCF_OFS_IRQ_MSK: r = RCF_SEL_MSK;
            default: r = RCF_SEL_NONE;
         endcase
      end
      return r;
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_q_r <= 2'h0;
      end else begin
         rst_q_r <= {rst_q_r[0], 1'b1};
      end
   end
   assign rst_n_s = rst_q_r[1];

   assign wsel = dec(ADDR_W'(s_r.aw_addr));
   assign rsel = dec(i_araddr);
   assign rise = s_r.evt_s2 & ~s_r.evt_s3;

   always_comb begin
      s_nxt = s_r;

      // Cause inputs sync, edge taken once per event
      // event capture
      s_nxt.evt_s1 = {i_evt_stk_ovf, i_evt_stk_unf, i_evt_wdt_win,
                      i_evt_wdt_to, i_evt_pin, i_evt_sw, i_evt_memory_violation_flag,
                      i_bor_armed};
      s_nxt.evt_s2 = s_r.evt_s1;
      s_nxt.evt_s3 = s_r.evt_s2;

      // Power-up cause caught once after reset release
      // power-on cause
      if (!s_r.strap_done) begin
         s_nxt.strap_done = 1'b1;
         s_nxt.flags_lo[`RCF_BIT_POR] = i_bor_cause;
         s_nxt.flags_lo[`RCF_BIT_BOR] = ~i_bor_cause;
      end

      // Write address and data taken in either order
      if (i_awvalid && s_r.awready) begin
         s_nxt.awready = 1'b0;
         // Upper address bits set map to an unmapped slot
         if (i_awaddr == ADDR_W'(8'(i_awaddr))) begin
            s_nxt.aw_addr = 8'(i_awaddr);
         end else begin
            s_nxt.aw_addr = 8'hFF;
         end
      end
      if (i_wvalid && s_r.wready) begin
         s_nxt.wready = 1'b0;
         s_nxt.wdata = i_wdata[7:0];
         s_nxt.wstrb0 = i_wstrb[0];
      end

      if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `RCF_RESP_OKAY;
         if (s_r.wstrb0) begin
            unique case (wsel)
               RCF_SEL_LO: s_nxt.flags_lo = s_r.wdata;
               RCF_SEL_HI: s_nxt.memory_violation_flag = s_r.wdata[`RCF_BIT_MEMORY_VIOLATION_FLAG];
               RCF_SEL_BOR: s_nxt.software_brownout_enable = s_r.wdata[`RCF_BIT_SOFTWARE_BROWNOUT_ENABLE];
               RCF_SEL_STS: s_nxt.irq_sts = s_r.irq_sts & ~s_r.wdata;
               RCF_SEL_MSK: s_nxt.irq_msk = s_r.wdata;
               RCF_SEL_NONE: s_nxt.bresp = `RCF_RESP_SLVERR;
            endcase
         end else if (wsel == RCF_SEL_NONE) begin
            s_nxt.bresp = `RCF_RESP_SLVERR;
         end
      end
      if (s_r.bvalid && i_bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // Hardware updates after the write so an event beats a clear
      // only the matching flag
      if (rise[7]) begin
         s_nxt.flags_lo[`RCF_BIT_STK_OVF] = 1'b1;
      end
      if (rise[6]) begin
         s_nxt.flags_lo[`RCF_BIT_STK_UNF] = 1'b1;
      end
      if (rise[5]) begin
         s_nxt.flags_lo[`RCF_BIT_WDT_WIN] = 1'b0;
      end
      if (rise[4]) begin
         s_nxt.flags_lo[`RCF_BIT_WDT_TO] = 1'b0;
      end
      if (rise[3]) begin
         s_nxt.flags_lo[`RCF_BIT_PIN] = 1'b0;
      end
      if (rise[2]) begin
         s_nxt.flags_lo[`RCF_BIT_SW] = 1'b0;
      end
      if (rise[1]) begin
         s_nxt.memory_violation_flag = 1'b0;
      end
      s_nxt.irq_sts = s_nxt.irq_sts | rise;
      s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);

      // Read channel
      if (i_arvalid && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `RCF_RESP_OKAY;
         s_nxt.rdata = 32'h0;
         unique case (rsel)
            RCF_SEL_LO: s_nxt.rdata[7:0] = s_r.flags_lo;
            RCF_SEL_HI: s_nxt.rdata[`RCF_BIT_MEMORY_VIOLATION_FLAG] = s_r.memory_violation_flag;
            RCF_SEL_BOR: begin
               s_nxt.rdata[`RCF_BIT_SOFTWARE_BROWNOUT_ENABLE] = s_r.software_brownout_enable;
               s_nxt.rdata[`RCF_BIT_BOR_RDY] = s_r.evt_s2[0];
            end
            RCF_SEL_STS: s_nxt.rdata[7:0] = s_r.irq_sts;
            RCF_SEL_MSK: s_nxt.rdata[7:0] = s_r.irq_msk;
            RCF_SEL_NONE: s_nxt.rresp = `RCF_RESP_SLVERR;
         endcase
      end
      if (s_r.rvalid && i_rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_awready = s_r.awready;
   assign o_wready = s_r.wready;
   assign o_bvalid = s_r.bvalid;
   assign o_bresp = s_r.bresp;
   assign o_arready = s_r.arready;
   assign o_rvalid = s_r.rvalid;
   assign o_rdata = s_r.rdata;
   assign o_rresp = s_r.rresp;
   assign o_software_brownout_enable = s_r.software_brownout_enable;
   assign o_irq = s_r.irq;

endmodule

// >>> tb/rcf_props.sv
// Port checks of the reset-cause flag block
module rcf_props #(
   parameter int ADDR_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_ar;
      i_arvalid && o_arready;
   endsequence
   sequence s_wr;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   chk_rd_answer: assert property (s_ar |=> o_rvalid && !o_arready)
      else $error("read not answered");
   chk_rd_hold: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata) && $stable(o_rresp))
      else $error("read data moved");
   chk_rd_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_rd_unmapped: assert property ((s_ar and
      (i_araddr == ADDR_W'(8'h14))) |=> o_rresp == 2'h2 && o_rdata == 32'h0)
      else $error("unmapped read accepted");
   chk_wr_answer: assert property (s_wr |=> !o_bvalid ##1 o_bvalid)
      else $error("write answer late");
   chk_wr_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while busy");
   chk_b_release: assert property (o_bvalid && i_bready |=>
      !o_bvalid && o_awready)
      else $error("write response not released");
   chk_r_release: assert property (o_rvalid && i_rready |=>
      !o_rvalid && o_arready)
      else $error("read response not released");
endmodule

bind rcf_top rcf_props #(.ADDR_W(ADDR_W)) u_props (.i_ref_clk, .i_rst_n,
   .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
   .i_rready, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
   .i_bready);

// >>> tb/tb_top.sv
// Self-checking bench of the reset-cause flag block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 0, i_rst_n = 0, i_bor_cause = 0, i_bor_armed = 1;
   logic [6:0] ev = 0;
   logic [7:0] i_awaddr = 0, i_araddr = 0, lo, hi;
   logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
   logic i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_software_brownout_enable, o_irq;
   logic [31:0] i_wdata = 0, o_rdata, d;
   logic [3:0] i_wstrb = 4'hF;
   logic [1:0] o_bresp, o_rresp, r;
   int errors = 0, comparisons = 0, k;
   rcf_top dut (.i_ref_clk, .i_rst_n, .i_bor_cause, .i_evt_stk_ovf(ev[0]),
      .i_evt_stk_unf(ev[1]), .i_evt_wdt_win(ev[2]), .i_evt_wdt_to(ev[3]),
      .i_evt_pin(ev[4]), .i_evt_sw(ev[5]), .i_evt_memory_violation_flag(ev[6]), .i_bor_armed,
      .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
      .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
      .o_software_brownout_enable, .o_irq);
   initial forever #4 i_ref_clk = ~i_ref_clk;
   task automatic report_and_stop;
      if (errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge i_ref_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
         if (o_bvalid) break;
      end
      r = o_bresp;
      i_bready <= 1'b0;
      if (n == 40) begin
         errors++;
         report_and_stop;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge i_ref_clk);
         if (o_arready) i_arvalid <= 1'b0;
         if (o_rvalid) break;
      end
      d = o_rdata;
      r = o_rresp;
      i_rready <= 1'b0;
      if (n == 40) begin
         errors++;
         report_and_stop;
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(d, {24'h0, e});
      chk(r, 2'h0);
   endtask
   function automatic logic [7:0] ev_bit(input int n);
      return (n < 6) ? (8'h80 >> n) : 8'h02;
   endfunction
   task automatic pulse(input int n);
      ev[n] <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      ev[n] <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
      if (n < 6) lo[7-n] = (n < 2);
      else hi[1] = 1'b0;
   endtask
   task automatic boot(input logic b);
      i_rst_n <= 1'b0;
      i_bor_cause <= b;
      repeat (10) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      lo = b ? 8'h3E : 8'h3D;
      hi = 8'h02;
   endtask
   initial begin
      k = $urandom(32'h14B833A8);
      boot(1'b0);
      rc(8'h00, 8'h3D);
      rc(8'h04, 8'h02);
      rc(8'h08, 8'h81);
      rd(8'h14);
      chk(r, 2'h2);
      chk(d, 32'h0);
      wr(8'h14, 32'hFF);
      chk(r, 2'h2);
      rc(8'h00, 8'h3D);
      wr(8'h10, 32'hFF);
      chk(r, 2'h0);
      rc(8'h10, 8'hFF);
      for (int i = 0; i < 14; i++) begin
         k = (i < 7) ? i : $urandom % 7;
         wr(8'h0C, 32'hFF);
         pulse(k);
         chk(o_irq, 1'b1);
         rc(8'h00, lo);
         rc(8'h04, hi);
         d = $urandom;
         wr(8'h00, d);
         chk(r, 2'h0);
         lo = d[7:0];
         wr(8'h04, d);
         hi = {6'h0, d[1], 1'b0};
         rc(8'h00, lo);
         rc(8'h04, hi);
         rc(8'h0C, ev_bit(k));
      end
      wr(8'h10, 32'h0);
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 1'b0);
      wr(8'h0C, 32'hFF);
      rc(8'h0C, 8'h00);
      i_bor_armed <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      rc(8'h08, 8'h80);
      wr(8'h08, 32'h0);
      repeat (2) @(posedge i_ref_clk);
      chk(o_software_brownout_enable, 1'b0);
      i_bor_armed <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      rc(8'h08, 8'h01);
      rc(8'h0C, 8'h01);
      wr(8'h08, 32'h80);
      rc(8'h08, 8'h81);
      chk(o_software_brownout_enable, 1'b1);
      i_wstrb <= 4'h0;
      wr(8'h00, ~{24'h0, lo});
      chk(r, 2'h0);
      i_wstrb <= 4'hF;
      rc(8'h00, lo);
      boot(1'b1);
      rc(8'h00, 8'h3E);
      rc(8'h04, 8'h02);
      report_and_stop;
   end
endmodule
